// ==== pcd_pin_change.sv ====
// pin change detector with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module pcd_pin_change #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire pcd_pkg::pcd_bus_t bus,
  output logic [7:0] rdata,
  // pins
  input wire logic [WIDTH-1:0] third_port_pin,
  input wire logic [7:0] fifth_port_pin,
  // status out
  output logic global_change_flag,
  output logic change_irq,
  output logic irq
);

  pcd_pkg::pcd_state_t s_r;
  pcd_pkg::pcd_state_t s_nxt;

  // edge and flag update
  function automatic logic [7:0] upd(input logic [7:0] flags,
                                     input logic [7:0] prev,
                                     input logic [7:0] now,
                                     input logic [7:0] ren,
                                     input logic [7:0] fen);
    upd = flags | (ren & now & ~prev) | (fen & ~now & prev);
  endfunction : upd

  logic [7:0] c_pin;
  logic [7:0] c_rise_ev;
  logic [7:0] c_fall_ev;
  logic [7:0] e_rise_ev;
  logic wr_cf;
  logic wr_ef;

  assign c_pin = 8'(third_port_pin);
  assign c_rise_ev = s_r.c_rise & c_pin & ~s_r.c_prev;
  assign c_fall_ev = s_r.c_fall & ~c_pin & s_r.c_prev;
  assign e_rise_ev = s_r.e_rise & fifth_port_pin & ~s_r.e_prev;
  assign wr_cf = bus.wr && bus.addr == pcd_pkg::ADDR_C_FLAGS;
  assign wr_ef = bus.wr && bus.addr == pcd_pkg::ADDR_E_FLAGS;

  // next state: software writes first, hardware sets win afterwards
  always_comb begin
    logic [7:0] cf;
    logic [7:0] ef;
    logic [2:0] ev;
    cf = 8'h00;
    ef = 8'h00;
    ev = 3'h0;
    s_nxt = s_r;
    s_nxt.c_prev = c_pin;
    s_nxt.e_prev = fifth_port_pin;
    cf = wr_cf ? bus.wdata : s_r.c_flags;
    ef = wr_ef ? (bus.wdata & pcd_pkg::E_MASK) : s_r.e_flags;
    if (bus.wr) begin
      unique case (bus.addr)
        pcd_pkg::ADDR_C_RISE: s_nxt.c_rise = bus.wdata;
        pcd_pkg::ADDR_C_FALL: s_nxt.c_fall = bus.wdata;
        pcd_pkg::ADDR_E_RISE: s_nxt.e_rise = bus.wdata & pcd_pkg::E_MASK;
        pcd_pkg::ADDR_CTRL: s_nxt.irq_en = bus.wdata[pcd_pkg::CTRL_IRQ_EN];
        pcd_pkg::ADDR_IRQ_MASK: s_nxt.irq_mask = bus.wdata[2:0];
        default: ;
      endcase
    end
    // gated edges only; disabled direction never sets a flag
    s_nxt.c_flags = upd(cf, s_r.c_prev, c_pin, s_r.c_rise, s_r.c_fall);
    s_nxt.e_flags = upd(ef, s_r.e_prev, fifth_port_pin, s_r.e_rise,
                        8'h00);
    s_nxt.global_flag = |{s_nxt.c_flags, s_nxt.e_flags};
    s_nxt.change_irq = s_nxt.global_flag & s_nxt.irq_en;
    // sticky event bits, write one to clear, set wins
    ev[pcd_pkg::ST_GLOBAL] = |{c_rise_ev, c_fall_ev, e_rise_ev};
    ev[pcd_pkg::ST_RISE] = |{c_rise_ev, e_rise_ev};
    ev[pcd_pkg::ST_FALL] = |c_fall_ev;
    s_nxt.irq_stat = s_r.irq_stat;
    if (bus.wr && bus.addr == pcd_pkg::ADDR_IRQ_STAT) begin
      s_nxt.irq_stat = s_r.irq_stat & ~bus.wdata[2:0];
    end
    s_nxt.irq_stat = (s_nxt.irq_stat | ev) & pcd_pkg::ST_MASK;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    // read data valid the cycle after the strobe only
    s_nxt.rdata = pcd_pkg::RESET_BYTE;
    if (bus.rd) begin
      unique case (bus.addr)
        pcd_pkg::ADDR_C_FLAGS: s_nxt.rdata = s_r.c_flags;
        pcd_pkg::ADDR_C_RISE: s_nxt.rdata = s_r.c_rise;
        pcd_pkg::ADDR_C_FALL: s_nxt.rdata = s_r.c_fall;
        pcd_pkg::ADDR_E_RISE: s_nxt.rdata = s_r.e_rise;
        pcd_pkg::ADDR_E_FLAGS: s_nxt.rdata = s_r.e_flags;
        pcd_pkg::ADDR_CTRL: s_nxt.rdata = {6'h00, s_r.global_flag,
                                           s_r.irq_en};
        pcd_pkg::ADDR_IRQ_STAT: s_nxt.rdata = {5'h00, s_r.irq_stat};
        pcd_pkg::ADDR_IRQ_MASK: s_nxt.rdata = {5'h00, s_r.irq_mask};
        default: s_nxt.rdata = pcd_pkg::RESET_BYTE;
      endcase
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign global_change_flag = s_r.global_flag;
  assign change_irq = s_r.change_irq;
  assign irq = s_r.irq;

  // checks
  chk_rise_sets_flag: assert property (@(posedge clk) disable iff (rst)
    (s_r.c_rise[0] && !s_r.c_prev[0] && c_pin[0])
      |=> s_r.c_flags[0])
    else $error("enabled rise did not set flag");
  chk_fall_sets_flag: assert property (@(posedge clk) disable iff (rst)
    (s_r.c_fall[1] && s_r.c_prev[1] && !c_pin[1])
      |=> s_r.c_flags[1])
    else $error("enabled fall did not set flag");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (s_r.c_flags[2] && !wr_cf) |=> s_r.c_flags[2])
    else $error("flag dropped without write");
  chk_flag_reset: assert property (@(posedge clk)
    rst |=> (s_r.c_flags == 8'h00 && s_r.e_flags == 8'h00))
    else $error("flags not cleared by reset");
  // global flag registers on the same edge as the pin flag it summarises
  chk_e_rise_global: assert property (@(posedge clk) disable iff (rst)
    (s_r.e_rise[3] && !s_r.e_prev[3] && fifth_port_pin[3])
      |=> (s_r.e_flags[3] && global_change_flag))
    else $error("fifth port rise not flagged");
  // a software write of a one is legal, so it is kept out of the antecedent
  chk_disabled_edge: assert property (@(posedge clk) disable iff (rst)
    (!s_r.c_rise[4] && !s_r.c_fall[4] && !s_r.c_flags[4] && !wr_cf)
      |=> !s_r.c_flags[4])
    else $error("disabled pin set its flag");
  chk_fall_ignored: assert property (@(posedge clk) disable iff (rst)
    (!s_r.c_fall[5] && !s_r.c_flags[5] && !wr_cf && s_r.c_prev[5] &&
     !c_pin[5]) |=> !s_r.c_flags[5])
    else $error("fall with fall detection off set flag");
  chk_e_disabled: assert property (@(posedge clk) disable iff (rst)
    (!s_r.e_rise[3] && !s_r.e_flags[3] && !wr_ef)
      |=> !s_r.e_flags[3])
    else $error("disabled fifth port pin set its flag");
  chk_e_sticky: assert property (@(posedge clk) disable iff (rst)
    (s_r.e_flags[3] && !wr_ef) |=> s_r.e_flags[3])
    else $error("fifth port flag dropped without write");
  chk_e_flag_bits: assert property (@(posedge clk) disable iff (rst)
    (s_r.e_flags & ~pcd_pkg::E_MASK) == 8'h00)
    else $error("unimplemented fifth port flag set");
  chk_rise_status: assert property (@(posedge clk) disable iff (rst)
    (|c_rise_ev) |=> s_r.irq_stat[pcd_pkg::ST_RISE])
    else $error("rise event missing from status");
  chk_fall_status: assert property (@(posedge clk) disable iff (rst)
    (|c_fall_ev) |=> s_r.irq_stat[pcd_pkg::ST_FALL])
    else $error("fall event missing from status");
  // without a write in between, flags can only grow, so the summary holds
  chk_global_follow: assert property (@(posedge clk) disable iff (rst)
    ((s_r.c_flags != 8'h00 || s_r.e_flags != 8'h00) && !bus.wr)
      |=> global_change_flag)
    else $error("global flag missing");
  chk_e_rise_bits: assert property (@(posedge clk) disable iff (rst)
    (s_r.e_rise & ~pcd_pkg::E_MASK) == 8'h00)
    else $error("unimplemented enable bit set");
  chk_irq_follow: assert property (@(posedge clk) disable iff (rst)
    (s_r.c_flags != 8'h00 && s_r.irq_en && !bus.wr) |=> change_irq)
    else $error("change irq missing");
  cov_c_rise: cover property (@(posedge clk) disable iff (rst)
    |c_rise_ev);
  cov_c_fall: cover property (@(posedge clk) disable iff (rst)
    |c_fall_ev);
  cov_e_rise: cover property (@(posedge clk) disable iff (rst)
    |e_rise_ev ##2 change_irq);
  cov_irq_clear: cover property (@(posedge clk) disable iff (rst)
    irq ##1 (bus.wr && bus.addr == pcd_pkg::ADDR_IRQ_STAT) ##2 !irq);

endmodule : pcd_pin_change
`default_nettype wire

// ==== pcd_pin_model.sv ====
// far-side model: third-port pins and fifth-port bit 3 driven at the levels the bench requests
`timescale 1ns/1ps
`default_nettype none
module pcd_pin_model (
  // clock
  input wire logic clk,
  // requested levels
  input wire logic [7:0] c_req,
  input wire logic e3_req,
  // pins
  output logic [7:0] third_port_pin,
  output logic [7:0] fifth_port_pin
);
  logic [2:0] junk_r = 3'h0;
  // undetected fifth-port bits churn so any stray detection shows up
  initial begin
    third_port_pin = 8'h00;
    fifth_port_pin = 8'h00;
  end
  always @(posedge clk) begin
    junk_r <= junk_r + 3'h1;
    third_port_pin <= c_req;
    fifth_port_pin <= {junk_r, junk_r[0], e3_req, junk_r};
  end
endmodule : pcd_pin_model
`default_nettype wire

// ==== pcd_pkg.sv ====
// package with register map, field layout and types for pin change detect
package pcd_pkg;

  // register addresses
  localparam logic [3:0] ADDR_C_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_C_RISE = 4'h1;
  localparam logic [3:0] ADDR_C_FALL = 4'h2;
  localparam logic [3:0] ADDR_E_RISE = 4'h3;
  localparam logic [3:0] ADDR_E_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;

  // field positions and reset values
  localparam int E_PIN = 3;
  localparam logic [7:0] E_MASK = 8'h08;
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_GLOBAL = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int ST_GLOBAL = 0;
  localparam int ST_RISE = 1;
  localparam int ST_FALL = 2;
  localparam logic [2:0] ST_MASK = 3'h7;

  // bus request bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcd_bus_t;

  // all block state
  typedef struct packed {
    logic [7:0] c_prev;
    logic [7:0] e_prev;
    logic [7:0] c_rise;
    logic [7:0] c_fall;
    logic [7:0] e_rise;
    logic [7:0] c_flags;
    logic [7:0] e_flags;
    logic irq_en;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic global_flag;
    logic irq;
    logic change_irq;
  } pcd_state_t;

endpackage : pcd_pkg

// ==== test_pcd_pin_change.sv ====
// self-checking bench for the pin change detector
`timescale 1ns/1ps
`default_nettype none
module test_pcd_pin_change;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pcd_pkg::pcd_bus_t bus = '0;
  logic [7:0] rdata, tp, fp, p;
  logic [7:0] c_req = 8'h00;
  logic e3_req = 1'b0;
  logic gflag, cirq, irq;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int compares = 0;
  int seed = 36;
  always #20 clk = ~clk;
  pcd_pin_model pins (.clk(clk), .c_req(c_req), .e3_req(e3_req),
    .third_port_pin(tp), .fifth_port_pin(fp));
  pcd_pin_change dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .third_port_pin(tp), .fifth_port_pin(fp), .global_change_flag(gflag),
    .change_irq(cirq), .irq(irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude;
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // strobes are held until the next call replaces them, so none is set twice
  task automatic bw(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask : bw
  task automatic br(input logic [3:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
  endtask : br
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clk);
  endtask : idle
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= bus.rd && !rst;
    if (rd_q) begin
      check(rdata, exp_q.pop_front());
    end
  end
  // hang guard
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // everything reads zero after reset, unmapped address 8 too
    for (int a = 0; a < 9; a++) begin
      br(4'(a), 8'h00);
    end
    p = 8'($random(seed)) | 8'h01;
    bw(pcd_pkg::ADDR_C_RISE, 8'hff);
    bw(pcd_pkg::ADDR_IRQ_MASK, 8'h07);
    c_req <= p;
    idle(4);
    br(pcd_pkg::ADDR_C_FLAGS, p);
    check({7'h0, gflag}, 8'h01);
    // falls while fall detection is off leave flags standing
    c_req <= 8'h00;
    idle(4);
    br(pcd_pkg::ADDR_C_FLAGS, p);
    bw(pcd_pkg::ADDR_C_FLAGS, 8'h00);
    bw(pcd_pkg::ADDR_C_RISE, 8'h00);
    bw(pcd_pkg::ADDR_C_FALL, 8'hff);
    c_req <= p;
    idle(4);
    br(pcd_pkg::ADDR_C_FLAGS, 8'h00);
    c_req <= 8'h00;
    idle(4);
    br(pcd_pkg::ADDR_C_FLAGS, p);
    bw(pcd_pkg::ADDR_C_FLAGS, 8'h5a);
    br(pcd_pkg::ADDR_C_FLAGS, 8'h5a);
    bw(pcd_pkg::ADDR_C_FLAGS, 8'h00);
    // only bit 3 exists; the churning neighbours must never flag
    bw(pcd_pkg::ADDR_E_RISE, 8'hff);
    br(pcd_pkg::ADDR_E_RISE, 8'h08);
    e3_req <= 1'b1;
    idle(6);
    br(pcd_pkg::ADDR_E_FLAGS, 8'h08);
    check({7'h0, gflag}, 8'h01);
    bw(pcd_pkg::ADDR_CTRL, 8'h01);
    idle(3);
    check({7'h0, cirq}, 8'h01);
    check({7'h0, irq}, 8'h01);
    bw(pcd_pkg::ADDR_IRQ_STAT, 8'h07);
    idle(3);
    check({7'h0, irq}, 8'h00);
    bw(pcd_pkg::ADDR_E_FLAGS, 8'h00);
    idle(3);
    check({6'h0, gflag, cirq}, 8'h00);
    conclude();
  end
endmodule : test_pcd_pin_change
`default_nettype wire
